// *** logic/servo_gate_pkg.sv ***
// Shared constants, types and register map of the servo enable and travel limit logic.
package servo_gate_pkg;
	// ============================================================
	// Register bus map, word index on a 4-bit address.
	localparam logic [3:0] CTRL_ADDR = 4'h0;
	localparam logic [3:0] ZERO_SPEED_ADDR = 4'h1;
	localparam logic [3:0] STATUS_ADDR = 4'h2;
	localparam logic [3:0] CONFIG_ADDR = 4'h3;
	localparam int CTRL_ALARM_RESET_BIT = 0;
	localparam int CTRL_ZERO_HOLD_BIT = 1;
	localparam logic ZERO_HOLD_RESET = 1'b0;
	localparam logic [15:0] ZERO_SPEED_RESET = 16'h0014;

	// ============================================================
	// Field positions and codes inside the latched parameter words.
	localparam int DIR_SEL_LSB = 4;
	localparam int ENABLE_SRC_LSB = 4;
	localparam int FWD_ASSIGN_LSB = 12;
	localparam int REV_ASSIGN_LSB = 0;
	localparam logic [3:0] ENABLE_SRC_INPUT = 4'h0;
	localparam logic [3:0] ENABLE_SRC_FORCED = 4'h9;
	localparam logic [3:0] FWD_ASSIGN_TERM_TWO = 4'h2;
	localparam logic [3:0] REV_ASSIGN_TERM_THREE = 4'h3;
	localparam logic [3:0] ASSIGN_DISABLED = 4'h8;
	localparam logic DIR_SEL_CCW_FWD = 1'b0;

	// ============================================================
	// Drive state machine, one-hot.
	typedef enum logic [4:0] {
		ST_OFF = 5'b00001,
		ST_ON = 5'b00010,
		ST_OT_STOP = 5'b00100,
		ST_OT_BLOCK = 5'b01000,
		ST_OT_HOLD = 5'b10000
	} drive_state_e;

	// Configuration caught once after reset.
	typedef struct packed {
		logic dir_sel;
		logic [3:0] enable_src;
		logic [3:0] fwd_assign;
		logic [3:0] rev_assign;
	} drive_cfg_s;

	// Status word as seen by software.
	typedef struct packed {
		logic stopped;
		logic rev_overtravel;
		logic fwd_overtravel;
		logic cfg_loaded;
		logic [4:0] state;
	} drive_status_s;
endpackage : servo_gate_pkg

// *** logic/pin_sync2.sv ***
// Two flip-flop synchroniser for a group of asynchronous pin levels.
`timescale 1ns/1ps
module pin_sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] pin_async,
	output logic [WIDTH-1:0] pin_sync
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	// The first stage feeds only the second stage.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= pin_async;
			sync_ff <= meta_ff;
		end
	end

	assign pin_sync = sync_ff;
endmodule : pin_sync2

// *** logic/quad_pulse_out.sv ***
// Quadrature pulse generator stepping one edge per request.
`timescale 1ns/1ps
module quad_pulse_out (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic step,
	input wire logic fwd,
	output logic phase_a,
	output logic phase_b
);
	logic [1:0] ab_ff;
	logic [1:0] nxt_ab;

	// Forward walks 00-01-11-10 so phase B leads; reverse walks back so phase A leads.
	always_comb begin
		nxt_ab = ab_ff;
		if (step) begin
			case (ab_ff)
				2'h0: nxt_ab = fwd ? 2'h1 : 2'h2;
				2'h1: nxt_ab = fwd ? 2'h3 : 2'h0;
				2'h3: nxt_ab = fwd ? 2'h2 : 2'h1;
				default: nxt_ab = fwd ? 2'h0 : 2'h3;
			endcase
		end
	end

	// Phase pair register.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ab_ff <= 2'h0;
		end else begin
			ab_ff <= nxt_ab;
		end
	end

	assign phase_a = ab_ff[1];
	assign phase_b = ab_ff[0];
endmodule : quad_pulse_out

// *** logic/servo_enable_and_travel_limit.sv ***
// Servo enable gating, direction mapping and travel limit control of the drive.
`timescale 1ns/1ps

// Function
// - Active enable energizes the motor and makes it drivable.
// - Inactive enable keeps the motor de-energized and undriven.
// - Servo-on is refused while the motor rotates.
// - Enable source 0 follows the input; 9 forces enable always active.
// - Forced enable energizes as soon as main power is present.
// - Forced enable re-energizes automatically after a resettable alarm is reset.
// - Direction select inverts physical rotation without changing command polarity.
// - Pulse output: B leads forward, A leads reverse, any direction select.
// - Default direction select makes forward counterclockwise; alternative makes it clockwise.
// - Forward limit on permits forward drive; off forbids it as overtravel.
// - Reverse limit on permits reverse drive; off forbids it as overtravel.
// - Forward assignment 2 uses terminal two; 8 disables the limit.
// - Reverse assignment 3 uses terminal three; 8 disables the limit.
// - An enabled limit showing overtravel forces the motor to stop unless the command points away from that limit.
// - Limits block command directions under either direction select.
// - After overtravel stop, base block unless zero hold is configured.
// - Brake release output stays on during overtravel.
module servo_enable_and_travel_limit (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic servo_enable_in,
	input wire logic main_power_ok,
	input wire logic input_terminal_two,
	input wire logic input_terminal_three,
	input wire logic [15:0] basic_function_param,
	input wire logic [15:0] input_assign_param_a,
	input wire logic [15:0] input_assign_param_b,
	input wire logic alarm_active,
	input wire logic signed [15:0] speed_cmd,
	input wire logic signed [15:0] speed_meas,
	input wire logic enc_step,
	input wire logic enc_ccw,
	output logic motor_energize,
	output logic signed [15:0] drive_cmd,
	output logic rotate_cw,
	output logic force_stop,
	output logic base_block,
	output logic zero_hold,
	output logic brake_release_output,
	output logic alarm_reset_pulse,
	output logic fwd_overtravel,
	output logic rev_overtravel,
	output logic pulse_out_phase_a,
	output logic pulse_out_phase_b
);
	import servo_gate_pkg::*;

	// ============================================================
	// Functions.

	// Magnitude of a signed word, saturated so the most negative value does not wrap.
	function automatic logic [15:0] mag16(input logic signed [15:0] v);
		logic [15:0] m;
		m = 16'h0000;
		if (v == 16'sh8000) begin
			m = 16'h7FFF;
		end else if (v < 0) begin
			m = 16'(-v);
		end else begin
			m = 16'(v);
		end
		return m;
	endfunction : mag16

	// Negation with saturation.
	function automatic logic signed [15:0] neg16(input logic signed [15:0] v);
		logic signed [15:0] r;
		r = 16'sh0000;
		if (v == 16'sh8000) begin
			r = 16'sh7FFF;
		end else begin
			r = -v;
		end
		return r;
	endfunction : neg16

	// ============================================================
	// Pin synchronisers.
	logic [3:0] pins_sync;
	logic enable_pin;
	logic power_pin;
	logic term_two;
	logic term_three;

	pin_sync2 #(
		.WIDTH(4)
	) u_pin_sync (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.pin_async({servo_enable_in, main_power_ok, input_terminal_two, input_terminal_three}),
		.pin_sync(pins_sync)
	);

	assign enable_pin = pins_sync[3];
	assign power_pin = pins_sync[2];
	assign term_two = pins_sync[1];
	assign term_three = pins_sync[0];

	// ============================================================
	// Configuration latch.
	drive_cfg_s cfg_ff;
	logic cfg_loaded_ff;
	logic pins_valid_ff;

	// Parameter words are caught in the first cycle after reset release and then frozen.
	// Synchronised limit pins read as overtravel until refilled, so flags wait one more edge.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cfg_ff <= '0;
			cfg_loaded_ff <= 1'b0;
			pins_valid_ff <= 1'b0;
		end else begin
			pins_valid_ff <= cfg_loaded_ff;
			if (!cfg_loaded_ff) begin
				cfg_ff.dir_sel <= basic_function_param[DIR_SEL_LSB];
				cfg_ff.enable_src <= input_assign_param_a[ENABLE_SRC_LSB +: 4];
				cfg_ff.fwd_assign <= input_assign_param_a[FWD_ASSIGN_LSB +: 4];
				cfg_ff.rev_assign <= input_assign_param_b[REV_ASSIGN_LSB +: 4];
				cfg_loaded_ff <= 1'b1;
			end
		end
	end

	// ============================================================
	// Register bus.
	logic zero_hold_cfg_ff;
	logic [15:0] zero_speed_ff;
	logic alarm_reset_ff;
	logic [31:0] rdata_ff;
	drive_status_s status_w;

	// Control and threshold registers; the alarm reset bit is a one-cycle pulse.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			zero_hold_cfg_ff <= ZERO_HOLD_RESET;
			zero_speed_ff <= ZERO_SPEED_RESET;
			alarm_reset_ff <= 1'b0;
		end else begin
			alarm_reset_ff <= 1'b0;
			if (reg_wr && reg_addr == CTRL_ADDR) begin
				alarm_reset_ff <= reg_wdata[CTRL_ALARM_RESET_BIT];
				zero_hold_cfg_ff <= reg_wdata[CTRL_ZERO_HOLD_BIT];
			end
			if (reg_wr && reg_addr == ZERO_SPEED_ADDR) begin
				zero_speed_ff <= reg_wdata[15:0];
			end
		end
	end

	// Read data stands in the cycle after the strobe only; unmapped reads give zero.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rdata_ff <= 32'h0000_0000;
		end else if (reg_rd) begin
			case (reg_addr)
				CTRL_ADDR: rdata_ff <= {30'h0, zero_hold_cfg_ff, 1'b0};
				ZERO_SPEED_ADDR: rdata_ff <= {16'h0000, zero_speed_ff};
				STATUS_ADDR: rdata_ff <= {23'h0, status_w};
				CONFIG_ADDR: rdata_ff <= {19'h0, cfg_ff};
				default: rdata_ff <= 32'h0000_0000;
			endcase
		end else begin
			rdata_ff <= 32'h0000_0000;
		end
	end

	// ============================================================
	// Enable source, limit decode and zero-speed detect.
	logic enable_req;
	logic fwd_limit_on;
	logic rev_limit_on;
	logic ot_fwd;
	logic ot_rev;
	logic stopped;
	logic cmd_fwd;
	logic cmd_rev;
	logic cmd_blocked;

	// Forced source follows main power alone; otherwise the pin must be active too.
	always_comb begin
		if (cfg_ff.enable_src == ENABLE_SRC_FORCED) begin
			enable_req = power_pin;
		end else begin
			enable_req = power_pin && enable_pin;
		end
	end

	// A switch that reads on permits its side; a disabled assignment always permits.
	assign fwd_limit_on = (cfg_ff.fwd_assign == ASSIGN_DISABLED) ? 1'b1 : term_two;
	assign rev_limit_on = (cfg_ff.rev_assign == ASSIGN_DISABLED) ? 1'b1 : term_three;
	assign ot_fwd = !fwd_limit_on;
	assign ot_rev = !rev_limit_on;

	// Limits are judged in the command frame, so direction select does not swap them.
	assign cmd_fwd = speed_cmd > 0;
	assign cmd_rev = speed_cmd < 0;
	assign cmd_blocked = (ot_fwd && cmd_fwd) || (ot_rev && cmd_rev);

	// Stopped when the measured speed magnitude is inside the threshold.
	assign stopped = mag16(speed_meas) <= zero_speed_ff;

	// ============================================================
	// Drive state machine.
	drive_state_e state_ff;
	drive_state_e nxt_state;

	// Alarm or lost enable always wins; overtravel stops then blocks or holds.
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_OFF: begin
				if (cfg_loaded_ff && enable_req && !alarm_active && stopped) begin
					nxt_state = ST_ON;
				end
			end
			ST_ON: begin
				if (!enable_req || alarm_active) begin
					nxt_state = ST_OFF;
				end else if (cmd_blocked || ((ot_fwd || ot_rev) && speed_cmd == 0)) begin
					nxt_state = ST_OT_STOP;
				end
			end
			ST_OT_STOP: begin
				if (!enable_req || alarm_active) begin
					nxt_state = ST_OFF;
				end else if (stopped) begin
					nxt_state = zero_hold_cfg_ff ? ST_OT_HOLD : ST_OT_BLOCK;
				end
			end
			ST_OT_BLOCK, ST_OT_HOLD: begin
				if (!enable_req || alarm_active) begin
					nxt_state = ST_OFF;
				end else if (!ot_fwd && !ot_rev) begin
					nxt_state = ST_ON;
				end else if (speed_cmd != 0 && !cmd_blocked) begin
					nxt_state = ST_ON;
				end
			end
			default: nxt_state = ST_OFF;
		endcase
	end

	// State register.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_ff <= ST_OFF;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ============================================================
	// Registered drive outputs.
	logic energize_ff;
	logic signed [15:0] drive_cmd_ff;
	logic rotate_cw_ff;
	logic force_stop_ff;
	logic base_block_ff;
	logic zero_hold_ff;
	logic brake_ff;
	logic ot_fwd_ff;
	logic ot_rev_ff;
	logic signed [15:0] nxt_drive_cmd;

	// Command passes only in the on state and is mirrored when forward means clockwise.
	always_comb begin
		nxt_drive_cmd = 16'sh0000;
		if (nxt_state == ST_ON && !cmd_blocked) begin
			if (cfg_ff.dir_sel == DIR_SEL_CCW_FWD) begin
				nxt_drive_cmd = speed_cmd;
			end else begin
				nxt_drive_cmd = neg16(speed_cmd);
			end
		end
	end

	// Energize, stop, block and brake outputs follow the next state.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			energize_ff <= 1'b0;
			drive_cmd_ff <= 16'sh0000;
			rotate_cw_ff <= 1'b0;
			force_stop_ff <= 1'b0;
			base_block_ff <= 1'b1;
			zero_hold_ff <= 1'b0;
			brake_ff <= 1'b0;
			ot_fwd_ff <= 1'b0;
			ot_rev_ff <= 1'b0;
		end else begin
			energize_ff <= nxt_state != ST_OFF && nxt_state != ST_OT_BLOCK;
			drive_cmd_ff <= nxt_drive_cmd;
			rotate_cw_ff <= nxt_drive_cmd < 0;
			force_stop_ff <= nxt_state == ST_OT_STOP;
			base_block_ff <= nxt_state == ST_OFF || nxt_state == ST_OT_BLOCK;
			zero_hold_ff <= nxt_state == ST_OT_HOLD;
			brake_ff <= nxt_state != ST_OFF;
			ot_fwd_ff <= pins_valid_ff && ot_fwd;
			ot_rev_ff <= pins_valid_ff && ot_rev;
		end
	end

	// ============================================================
	// Encoder pulse output in the command frame.
	logic enc_cmd_fwd;
	logic phase_a_w;
	logic phase_b_w;
	logic phase_a_ff;
	logic phase_b_ff;

	// Undo the direction select so the phase order follows command polarity.
	assign enc_cmd_fwd = (cfg_ff.dir_sel == DIR_SEL_CCW_FWD) ? enc_ccw : !enc_ccw;

	quad_pulse_out u_quad (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.step(enc_step && cfg_loaded_ff),
		.fwd(enc_cmd_fwd),
		.phase_a(phase_a_w),
		.phase_b(phase_b_w)
	);

	// Retime the phases so the outputs come from flip-flops.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			phase_a_ff <= 1'b0;
			phase_b_ff <= 1'b0;
		end else begin
			phase_a_ff <= phase_a_w;
			phase_b_ff <= phase_b_w;
		end
	end

	// ============================================================
	// Status and port assignments.
	assign status_w.stopped = stopped;
	assign status_w.rev_overtravel = ot_rev_ff;
	assign status_w.fwd_overtravel = ot_fwd_ff;
	assign status_w.cfg_loaded = cfg_loaded_ff;
	assign status_w.state = state_ff;

	assign reg_rdata = rdata_ff;
	assign motor_energize = energize_ff;
	assign drive_cmd = drive_cmd_ff;
	assign rotate_cw = rotate_cw_ff;
	assign force_stop = force_stop_ff;
	assign base_block = base_block_ff;
	assign zero_hold = zero_hold_ff;
	assign brake_release_output = brake_ff;
	assign alarm_reset_pulse = alarm_reset_ff;
	assign fwd_overtravel = ot_fwd_ff;
	assign rev_overtravel = ot_rev_ff;
	assign pulse_out_phase_a = phase_a_ff;
	assign pulse_out_phase_b = phase_b_ff;
endmodule : servo_enable_and_travel_limit

// *** sim/servo_gate_chk.sv ***
// Port checker for the servo enable and travel limit block.
`timescale 1ns/1ps
module servo_gate_chk
	import servo_gate_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic alarm_active,
	input wire logic motor_energize,
	input wire logic signed [15:0] drive_cmd,
	input wire logic rotate_cw,
	input wire logic force_stop,
	input wire logic base_block,
	input wire logic zero_hold,
	input wire logic brake_release_output,
	input wire logic alarm_reset_pulse
);
	// ============================================================
	// Assertions, all in the one clock domain.
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	a_energy_vs_block: assert property (motor_energize != base_block)
		else $error("energize and base block agree");
	a_off_no_cmd: assert property (!motor_energize |-> drive_cmd == 16'sh0000)
		else $error("command while de-energized");
	a_stop_no_cmd: assert property (force_stop |-> drive_cmd == 16'sh0000)
		else $error("command during forced stop");
	a_hold_keeps_brake: assert property (zero_hold |-> motor_energize && brake_release_output)
		else $error("zero hold without energy or brake release");
	a_cw_follows_sign: assert property (rotate_cw == drive_cmd[15])
		else $error("rotation flag differs from command sign");
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside its cycle");
	a_alarm_pulse: assert property (alarm_reset_pulse ==
		$past(reg_wr && reg_addr == CTRL_ADDR && reg_wdata[0]))
		else $error("alarm reset pulse mistimed");
	a_alarm_drops: assert property (alarm_active |=> !motor_energize)
		else $error("energized during alarm");
endmodule : servo_gate_chk

bind servo_enable_and_travel_limit servo_gate_chk u_chk (.ref_clk, .rst_n, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .alarm_active, .motor_energize, .drive_cmd,
	.rotate_cw, .force_stop, .base_block, .zero_hold, .brake_release_output,
	.alarm_reset_pulse);

// *** sim/limit_host_model.sv ***
// Host controller and normally closed limit switches facing the drive.
`timescale 1ns/1ps
module limit_host_model (
	input wire logic ref_clk,
	input wire logic en_cmd,
	input wire logic fwd_hit,
	input wire logic rev_hit,
	input wire logic energized,
	input wire logic signed [15:0] cmd_val,
	output logic servo_enable_in,
	output logic input_terminal_two,
	output logic input_terminal_three,
	output logic signed [15:0] speed_cmd
);
	// A hit opens the contact, so the pin reads low as a broken wire would.
	always @(posedge ref_clk) begin
		input_terminal_two <= !fwd_hit;
		input_terminal_three <= !rev_hit;
		servo_enable_in <= en_cmd;
		speed_cmd <= energized ? cmd_val : 16'sh0000;
	end
endmodule : limit_host_model

// *** sim/tb_top.sv ***
// Self-checking bench for the servo enable and travel limit block.
`timescale 1ns/1ps
module tb_top;
	import servo_gate_pkg::*;
	logic ref_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, main_power_ok = 1;
	logic alarm_active = 0, enc_step = 0, enc_ccw = 0, en_cmd = 0, fwd_hit = 0, rev_hit = 0;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic [15:0] basic_function_param = 16'h0, input_assign_param_a = 16'h2000;
	logic [15:0] input_assign_param_b = 16'h0003;
	logic signed [15:0] speed_meas = 16'sh0, cmd_val = 16'sh0, speed_cmd, drive_cmd;
	logic servo_enable_in, input_terminal_two, input_terminal_three, motor_energize;
	logic rotate_cw, force_stop, base_block, zero_hold, brake_release_output;
	logic alarm_reset_pulse, fwd_overtravel, rev_overtravel;
	logic pulse_out_phase_a, pulse_out_phase_b;
	int err_total = 0, num_checks = 0, cycles = 0;
	logic [31:0] d;
	servo_enable_and_travel_limit u_dut (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .servo_enable_in, .main_power_ok, .input_terminal_two,
		.input_terminal_three, .basic_function_param, .input_assign_param_a,
		.input_assign_param_b, .alarm_active, .speed_cmd, .speed_meas, .enc_step, .enc_ccw,
		.motor_energize, .drive_cmd, .rotate_cw, .force_stop, .base_block, .zero_hold,
		.brake_release_output, .alarm_reset_pulse, .fwd_overtravel, .rev_overtravel,
		.pulse_out_phase_a, .pulse_out_phase_b);
	limit_host_model u_host (.ref_clk, .en_cmd, .fwd_hit, .rev_hit,
		.energized(motor_energize), .cmd_val, .servo_enable_in, .input_terminal_two,
		.input_terminal_three, .speed_cmd);
	// ============================================================
	// Clock and hang guard.
	initial begin
		forever #50 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			err_total++;
			end_of_test();
		end
	end
	// ============================================================
	// Shared helpers.
	task cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : cyc
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task rd(input logic [3:0] a);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd
	task do_reset(input logic [15:0] bf, input logic [15:0] pa, input logic pw);
		cyc(1);
		rst_n <= 1'b0;
		basic_function_param <= bf;
		input_assign_param_a <= pa;
		main_power_ok <= pw;
		cyc(20);
		rst_n <= 1'b1;
		cyc(4);
	endtask : do_reset
	// Four encoder steps compared against the expected A,B pairs.
	task t_enc(input logic ccw, input logic [7:0] seq);
		for (int i = 0; i < 4; i++) begin
			@(posedge ref_clk);
			enc_step <= 1'b1;
			enc_ccw <= ccw;
			@(posedge ref_clk);
			enc_step <= 1'b0;
			cyc(2);
			#1 chk({pulse_out_phase_a, pulse_out_phase_b}, seq[7-2*i -: 2]);
		end
		$display("encoder test done");
	endtask : t_enc
	// ============================================================
	// Scenarios.
	task t_regs;
		rd(ZERO_SPEED_ADDR);
		chk(d, 32'h14);
		rd(CONFIG_ADDR);
		chk(d, 32'h023);
		wr(STATUS_ADDR, 32'hFF);
		rd(STATUS_ADDR);
		chk(d, 32'h121);
		rd(4'hF);
		chk(d, 32'h0);
		wr(CTRL_ADDR, 32'h1);
		$display("register test done");
	endtask : t_regs
	task t_enable;
		speed_meas <= 16'sh0015;
		en_cmd <= 1'b1;
		cyc(6);
		#1 chk(motor_energize, 0);
		cyc(1);
		speed_meas <= 16'shFFEC;
		cmd_val <= 16'sh0100;
		cyc(7);
		#1 chk(motor_energize, 1);
		chk(drive_cmd, 32'h100);
		chk(rotate_cw, 0);
		cyc(1);
		en_cmd <= 1'b0;
		speed_meas <= 16'sh0;
		cyc(5);
		#1 chk(motor_energize, 0);
		$display("enable test done");
	endtask : t_enable
	task t_limit(input logic s, input logic h);
		wr(CTRL_ADDR, {30'h0, h, 1'b0});
		en_cmd <= 1'b1;
		cmd_val <= s ? -16'sh0100 : 16'sh0100;
		cyc(8);
		speed_meas <= 16'sh0200;
		fwd_hit <= !s;
		rev_hit <= s;
		cyc(5);
		#1 chk(force_stop, 1);
		chk(s ? rev_overtravel : fwd_overtravel, 1);
		chk(brake_release_output, 1);
		cyc(1);
		speed_meas <= 16'sh0;
		cyc(5);
		#1 chk(base_block, !h);
		chk(zero_hold, h);
		chk(brake_release_output, 1);
		cyc(1);
		{fwd_hit, rev_hit, en_cmd, cmd_val} <= '0;
		cyc(6);
		$display("limit test done");
	endtask : t_limit
	task t_forced;
		#1 chk(motor_energize, 0);
		cyc(1);
		input_assign_param_a <= 16'h0000;
		rd(CONFIG_ADDR);
		chk(d, 32'h1983);
		cyc(1);
		main_power_ok <= 1'b1;
		cmd_val <= 16'sh0100;
		fwd_hit <= 1'b1;
		cyc(8);
		#1 chk(motor_energize, 1);
		chk(drive_cmd, 32'hFFFFFF00);
		chk(rotate_cw, 1);
		chk(fwd_overtravel, 0);
		cyc(1);
		speed_meas <= 16'sh0200;
		cmd_val <= -16'sh0100;
		rev_hit <= 1'b1;
		cyc(5);
		#1 chk(force_stop, 1);
		cyc(1);
		{speed_meas, cmd_val, fwd_hit, rev_hit} <= '0;
		alarm_active <= 1'b1;
		cyc(3);
		#1 chk(motor_energize, 0);
		wr(CTRL_ADDR, 32'h1);
		alarm_active <= 1'b0;
		cyc(5);
		#1 chk(motor_energize, 1);
		$display("forced test done");
	endtask : t_forced
	// Reverse limit switched off by its assignment: an open switch neither stops nor flags.
	task t_rev_off;
		cyc(1);
		input_assign_param_b <= 16'h0008;
		do_reset(16'h0000, 16'h2000, 1'b1);
		en_cmd <= 1'b1;
		cmd_val <= -16'sh0100;
		rev_hit <= 1'b1;
		cyc(8);
		#1 chk(rev_overtravel, 0);
		chk(force_stop, 0);
		chk(drive_cmd, 32'hFFFFFF00);
		$display("reverse disable test done");
	endtask : t_rev_off
	// ============================================================
	// Main sequence and verdict.
	task end_of_test;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_of_test
	initial begin
		do_reset(16'h0000, 16'h2000, 1'b1);
		t_regs();
		t_enable();
		for (int i = 0; i < 4; i++) begin
			t_limit(i[0], i[1]);
		end
		t_enc(1'b1, 8'b01111000);
		t_enc(1'b0, 8'b10110100);
		do_reset(16'h0010, 16'h8090, 1'b0);
		t_enc(1'b0, 8'b01111000);
		t_forced();
		t_rev_off();
		end_of_test();
	end
endmodule : tb_top
